// >>> verilog/comparator_config_regs.sv
// Purpose: register bank for comparator-0 mux/mode and comparator-1 control
// Assumes: reads are combinational, writes take effect at the clock edge
// Notes: unused mux codes 5..7 select no pin
module comparator_config_regs
    import cmp_regs_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // package strap: 1 for the larger package
    input wire logic pkg_large,
    // special function register access
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // comparator-0 side
    input wire logic cmp0_rise_flag,
    input wire logic cmp0_fall_flag,
    output logic [2:0] cmp0_inverting_input_sel,
    output logic [2:0] cmp0_noninverting_input_sel,
    output logic [5:0] cmp0_neg_pin,
    output logic [5:0] cmp0_pos_pin,
    output logic cmp0_rise_irq_en,
    output logic cmp0_fall_irq_en,
    output logic [1:0] cmp0_response_mode,
    output logic cmp0_irq,
    // comparator-1 side
    input wire logic cmp1_analog_out,
    output logic cmp1_enable_bit,
    output logic [1:0] cmp1_pos_hyst_code,
    output logic [1:0] cmp1_neg_hyst_code,
    output logic cmp1_pin_out
);
    logic [7:0] mux_r;
    logic [7:0] mode_r;
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic sync1_r;
    logic sync2_r;
    logic prev_r;
    logic rise_evt;
    logic fall_evt;
    logic wr_mux;
    logic wr_mode;
    logic wr_ctrl;
    logic [2:0] nsel;
    logic [2:0] psel;

    // address decode
    assign wr_mux = sfr_wr && (sfr_addr == CMP0_MUX_ADDR);
    assign wr_mode = sfr_wr && (sfr_addr == CMP0_MODE_ADDR);
    assign wr_ctrl = sfr_wr && (sfr_addr == CMP1_CTRL_ADDR);
    assign sfr_hit = (sfr_rd || sfr_wr) && ((sfr_addr == CMP0_MUX_ADDR) ||
                     (sfr_addr == CMP0_MODE_ADDR) || (sfr_addr == CMP1_CTRL_ADDR));

    // read mux; unmapped addresses return zero
    assign sfr_rdata = (sfr_addr == CMP0_MUX_ADDR) ? mux_r :
                       (sfr_addr == CMP0_MODE_ADDR) ? mode_r :
                       (sfr_addr == CMP1_CTRL_ADDR) ? {ctrl_r[7], sync2_r, ctrl_r[5:0]} : 8'h00;

    // mux and mode registers keep only their used bits
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            mux_r <= CMP0_MUX_RST;
            mode_r <= CMP0_MODE_RST;
        end
        else
        begin
            if (wr_mux)
                mux_r <= sfr_wdata & MUX_WR_MASK;
            if (wr_mode)
                mode_r <= sfr_wdata & MODE_WR_MASK;
        end
    end

    // comparator-0 field outputs
    assign nsel = mux_r[NSEL_LSB +: 3];
    assign psel = mux_r[PSEL_LSB +: 3];
    assign cmp0_inverting_input_sel = nsel;
    assign cmp0_noninverting_input_sel = psel;
    assign cmp0_rise_irq_en = mode_r[RISE_BIT];
    assign cmp0_fall_irq_en = mode_r[FALL_BIT];
    assign cmp0_response_mode = mode_r[1:0];

    // package-dependent pin translation
    assign cmp0_neg_pin = (int'(nsel) >= MUX_CODES) ? NO_PIN :
                          (pkg_large ? NEG_PIN_LARGE[nsel] : NEG_PIN_SMALL[nsel]);
    assign cmp0_pos_pin = (int'(psel) >= MUX_CODES) ? NO_PIN :
                          (pkg_large ? POS_PIN_LARGE[psel] : POS_PIN_SMALL[psel]);

    // flag and enable gating for comparator-0 interrupt
    assign cmp0_irq = (cmp0_rise_flag && mode_r[RISE_BIT]) || (cmp0_fall_flag && mode_r[FALL_BIT]);

    // two-stage synchronizer; only sync2 is used downstream
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
        end
        else
        begin
            sync1_r <= cmp1_analog_out;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end
    assign rise_evt = sync2_r && !prev_r;
    assign fall_evt = !sync2_r && prev_r;

    // control next value: edge set wins over software clear
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl)
        begin
            ctrl_nxt = {sfr_wdata[7], 1'b0, sfr_wdata[5:0]};
        end
        ctrl_nxt[OUT_BIT] = 1'b0;
        if (rise_evt)
            ctrl_nxt[RISE_BIT] = 1'b1;
        if (fall_evt)
            ctrl_nxt[FALL_BIT] = 1'b1;
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            ctrl_r <= CMP1_CTRL_RST;
        else
            ctrl_r <= ctrl_nxt;
    end

    assign cmp1_enable_bit = ctrl_r[EN_BIT];
    assign cmp1_pos_hyst_code = ctrl_r[HYP_LSB +: 2];
    assign cmp1_neg_hyst_code = ctrl_r[HYN_LSB +: 2];
    // disabled comparator drives its port pin low
    assign cmp1_pin_out = ctrl_r[EN_BIT] && sync2_r;

    // unused bits stay zero in storage and on readback
    a_mux_unused: assert property (@(posedge mclk) disable iff (sys_rst)
        (mux_r[7] == 1'b0) && (mux_r[3] == 1'b0))
        else $error("mux unused bits set");
    a_mux_read: assert property (@(posedge mclk) disable iff (sys_rst)
        (sfr_addr == CMP0_MUX_ADDR) |-> ((sfr_rdata[7] == 1'b0) && (sfr_rdata[3] == 1'b0)))
        else $error("mux unused bits read back");
    a_mode_unused: assert property (@(posedge mclk) disable iff (sys_rst)
        (mode_r & ~MODE_WR_MASK) == 8'h00)
        else $error("mode unused bits set");
    a_mode_read: assert property (@(posedge mclk) disable iff (sys_rst)
        (sfr_addr == CMP0_MODE_ADDR) |-> ((sfr_rdata & ~MODE_WR_MASK) == 8'h00))
        else $error("mode unused bits read back");

    // comparator-0 fields follow the last write one cycle later; unused codes select no pin, valid codes a pin
    a_mux_write: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_mux |=> ((cmp0_inverting_input_sel == $past(sfr_wdata[6:4]))
        && (cmp0_noninverting_input_sel == $past(sfr_wdata[2:0]))))
        else $error("mux write lost");
    a_mode_write: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_mode |=> ((cmp0_response_mode == $past(sfr_wdata[1:0])) && (cmp0_rise_irq_en == $past(sfr_wdata[5]))
        && (cmp0_fall_irq_en == $past(sfr_wdata[4]))))
        else $error("mode write lost");
    a_pin_unused: assert property (@(posedge mclk) disable iff (sys_rst)
        (int'(nsel) >= MUX_CODES) |-> (cmp0_neg_pin == NO_PIN))
        else $error("unused code drives a pin");
    a_pin_valid: assert property (@(posedge mclk) disable iff (sys_rst)
        (int'(psel) < MUX_CODES) |-> (cmp0_pos_pin != NO_PIN))
        else $error("valid code selects no pin");

    // comparator-0 request: each enabled flag raises it, nothing else does
    a_irq_gate: assert property (@(posedge mclk) disable iff (sys_rst)
        (!mode_r[RISE_BIT] && !mode_r[FALL_BIT]) |-> !cmp0_irq)
        else $error("irq not gated");
    a_irq_rise: assert property (@(posedge mclk) disable iff (sys_rst)
        (cmp0_rise_flag && cmp0_rise_irq_en) |-> cmp0_irq)
        else $error("rise irq missing");
    a_irq_fall: assert property (@(posedge mclk) disable iff (sys_rst)
        (cmp0_fall_flag && cmp0_fall_irq_en) |-> cmp0_irq)
        else $error("fall irq missing");
    a_irq_cause: assert property (@(posedge mclk) disable iff (sys_rst)
        cmp0_irq |-> ((cmp0_rise_flag && cmp0_rise_irq_en) || (cmp0_fall_flag && cmp0_fall_irq_en)))
        else $error("irq without cause");

    // comparator-1 control fields, readback and sticky flags
    a_ctrl_write: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_ctrl |=> ((cmp1_enable_bit == $past(sfr_wdata[7])) && (cmp1_pos_hyst_code == $past(sfr_wdata[3:2]))
        && (cmp1_neg_hyst_code == $past(sfr_wdata[1:0]))))
        else $error("control write lost");
    a_out_read: assert property (@(posedge mclk) disable iff (sys_rst)
        (sfr_addr == CMP1_CTRL_ADDR) |-> (sfr_rdata[OUT_BIT] == sync2_r))
        else $error("output state not read back");
    a_rise_set: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(sync2_r) |=> ctrl_r[RISE_BIT])
        else $error("rise flag not set");
    a_fall_set: assert property (@(posedge mclk) disable iff (sys_rst)
        $fell(sync2_r) |=> ctrl_r[FALL_BIT])
        else $error("fall flag not set");
    a_flag_sticky: assert property (@(posedge mclk) disable iff (sys_rst)
        (ctrl_r[RISE_BIT] && !wr_ctrl) |=> ctrl_r[RISE_BIT])
        else $error("rise flag dropped");
    a_fall_sticky: assert property (@(posedge mclk) disable iff (sys_rst)
        (ctrl_r[FALL_BIT] && !wr_ctrl) |=> ctrl_r[FALL_BIT])
        else $error("fall flag dropped");
    a_rise_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
        (!rise_evt && !(wr_ctrl && sfr_wdata[RISE_BIT]) && !ctrl_r[RISE_BIT]) |=> !ctrl_r[RISE_BIT])
        else $error("rise flag set without edge");
    a_fall_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
        (!fall_evt && !(wr_ctrl && sfr_wdata[FALL_BIT]) && !ctrl_r[FALL_BIT]) |=> !ctrl_r[FALL_BIT])
        else $error("fall flag set without edge");

    // synchronizer depth and the port pin
    a_sync_delay: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(cmp1_analog_out) ##1 cmp1_analog_out |=> sync2_r)
        else $error("sync latency wrong");
    a_sync_stage: assert property (@(posedge mclk) disable iff (sys_rst)
        sync2_r == $past(sync1_r))
        else $error("sync stage skipped");
    a_pin_low: assert property (@(posedge mclk) disable iff (sys_rst)
        !cmp1_enable_bit |-> !cmp1_pin_out)
        else $error("disabled pin not low");
    a_pin_follow: assert property (@(posedge mclk) disable iff (sys_rst)
        cmp1_enable_bit |-> (cmp1_pin_out == sync2_r))
        else $error("enabled pin not following");
endmodule

// >>> common/cmp_regs_pkg.sv
// Purpose: constants for the comparator configuration register bank
// Assumes: 8-bit special function register space, byte-wide accesses
// Notes: rule summary follows
// Function
// - input select bits 7 and 3 read zero, writes ignored.
// - bits 6-4 pick comparator-0 inverting input pin, codes 0..4.
// - bits 2-0 pick comparator-0 non-inverting input pin, codes 0..4.
// - mux codes map to different pins for small and large package.
// - mode register bits 7-6 and 3-2 read zero, writes ignored.
// - mode bit 5 gates comparator-0 rising-edge interrupt.
// - mode bit 4 gates comparator-0 falling-edge interrupt.
// - mode bits 1-0 pick response mode, 0 fastest, 3 lowest power.
// - comparator-1 control bit 7 enables comparator 1.
// - control bit 6 is read-only synchronized comparator-1 output.
// - control bit 5 sets on comparator-1 rising output edge.
// - control bit 4 sets on comparator-1 falling output edge.
// - control bits 3-2 are positive hysteresis code to the core.
// - control bits 1-0 are negative hysteresis code to the core.
// - edge flags stay set until software writes zero.
// - disabled comparator output to port pin is forced low.
package cmp_regs_pkg;
    localparam logic [7:0] CMP1_CTRL_ADDR = 8'h9a;
    localparam logic [7:0] CMP0_MODE_ADDR = 8'h9d;
    localparam logic [7:0] CMP0_MUX_ADDR = 8'h9f;
    localparam logic [7:0] CMP1_CTRL_RST = 8'h00;
    localparam logic [7:0] CMP0_MODE_RST = 8'h02;
    localparam logic [7:0] CMP0_MUX_RST = 8'h00;
    localparam logic [7:0] MUX_WR_MASK = 8'h77;
    localparam logic [7:0] MODE_WR_MASK = 8'h33;
    localparam int EN_BIT = 7;
    localparam int OUT_BIT = 6;
    localparam int RISE_BIT = 5;
    localparam int FALL_BIT = 4;
    localparam int NSEL_LSB = 4;
    localparam int PSEL_LSB = 0;
    localparam int HYP_LSB = 2;
    localparam int HYN_LSB = 0;
    localparam int MUX_CODES = 5;
    // pin numbers coded as port*8+bit, one table per input and package
    localparam logic [5:0] NEG_PIN_SMALL [MUX_CODES] = '{6'h09, 6'h0d, 6'h11, 6'h15, 6'h01};
    localparam logic [5:0] NEG_PIN_LARGE [MUX_CODES] = '{6'h11, 6'h16, 6'h1d, 6'h24, 6'h04};
    localparam logic [5:0] POS_PIN_SMALL [MUX_CODES] = '{6'h08, 6'h0c, 6'h10, 6'h14, 6'h00};
    localparam logic [5:0] POS_PIN_LARGE [MUX_CODES] = '{6'h10, 6'h15, 6'h1c, 6'h23, 6'h03};
    localparam logic [5:0] NO_PIN = 6'h3f;
endpackage

// >>> verification/cmp1_core_model.sv
// Purpose: behavioural comparator-1 analog core
// Assumes: bench sets the input difference as a level
// Notes: output is asynchronous to mclk
module cmp1_core_model (
    // enable from the register bank, input difference from the bench
    input wire logic enable,
    input wire logic diff_pos,
    // analog decision
    output logic out
);
    timeunit 1ns;
    timeprecision 1ps;
    // settling delay keeps edges away from mclk; an idle core rests low
    always @(enable or diff_pos)
        out <= #2 enable & diff_pos;
endmodule

// >>> verification/testbench.sv
// Purpose: self-checking bench for the comparator register bank
// Assumes: reads are combinational, writes land at the next mclk edge
// Notes: inputs move on the falling edge only
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module testbench
    import cmp_regs_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, sys_rst = 1, pkg_large = 0, sfr_wr = 0, sfr_rd = 0, level = 0;
    logic cmp0_rise_flag = 0, cmp0_fall_flag = 0, sfr_hit, cmp0_irq, cmp1_analog_out;
    logic cmp0_rise_irq_en, cmp0_fall_irq_en, cmp1_enable_bit, cmp1_pin_out;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    logic [2:0] cmp0_inverting_input_sel, cmp0_noninverting_input_sel;
    logic [5:0] cmp0_neg_pin, cmp0_pos_pin;
    logic [1:0] cmp0_response_mode, cmp1_pos_hyst_code, cmp1_neg_hyst_code;
    int err_total = 0, n_tests = 0;
    comparator_config_regs comparator_config_regs_inst (.mclk, .sys_rst, .pkg_large, .sfr_addr,
        .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata, .sfr_hit, .cmp0_rise_flag, .cmp0_fall_flag,
        .cmp0_inverting_input_sel, .cmp0_noninverting_input_sel, .cmp0_neg_pin, .cmp0_pos_pin,
        .cmp0_rise_irq_en, .cmp0_fall_irq_en, .cmp0_response_mode, .cmp0_irq, .cmp1_analog_out,
        .cmp1_enable_bit, .cmp1_pos_hyst_code, .cmp1_neg_hyst_code, .cmp1_pin_out);
    cmp1_core_model cmp1_core_model_inst (.enable(cmp1_enable_bit), .diff_pos(level),
        .out(cmp1_analog_out));
    // 200 MHz clock
    initial
    begin
        forever #2.5 mclk = ~mclk;
    end
    function automatic logic [5:0] pin_of(int c, logic big, logic neg);
        if (c > 4)
            return NO_PIN;
        if (neg)
            return big ? NEG_PIN_LARGE[c] : NEG_PIN_SMALL[c];
        return big ? POS_PIN_LARGE[c] : POS_PIN_SMALL[c];
    endfunction
    // one-cycle write strobe; a gap cycle follows so strobes never merge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        sfr_rd = 1'b0;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge mclk);
        sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        #1;
        `CHK("rdata", e, sfr_rdata)
        `CHK("hit", (a == CMP0_MUX_ADDR) || (a == CMP0_MODE_ADDR) || (a == CMP1_CTRL_ADDR), sfr_hit)
    endtask
    task automatic t_reset;
        rd(CMP0_MUX_ADDR, 8'h00);
        rd(CMP0_MODE_ADDR, 8'h02);
        rd(CMP1_CTRL_ADDR, 8'h00);
        rd(8'h9b, 8'h00);
        $display("t_reset done");
    endtask
    task automatic t_mux;
        for (int c = 0; c < 8; c++)
        begin
            wr(CMP0_MUX_ADDR, {1'b1, 3'(c), 1'b1, 3'(7 - c)});
            rd(CMP0_MUX_ADDR, {1'b0, 3'(c), 1'b0, 3'(7 - c)});
            `CHK("nsel", 3'(c), cmp0_inverting_input_sel)
            `CHK("psel", 3'(7 - c), cmp0_noninverting_input_sel)
            for (int b = 0; b < 2; b++)
            begin
                @(negedge mclk);
                pkg_large = b[0];
                #1;
                `CHK("npin", pin_of(c, b[0], 1'b1), cmp0_neg_pin)
                `CHK("ppin", pin_of(7 - c, b[0], 1'b0), cmp0_pos_pin)
            end
        end
        $display("t_mux done");
    endtask
    task automatic t_mode;
        for (int i = 0; i < 16; i++)
        begin
            wr(CMP0_MODE_ADDR, {2'b11, i[3:2], 2'b11, i[1:0]});
            rd(CMP0_MODE_ADDR, {2'b00, i[3:2], 2'b00, i[1:0]});
            @(negedge mclk);
            cmp0_rise_flag = i[1];
            cmp0_fall_flag = i[0];
            #1;
            `CHK("mode", 4'(i), {cmp0_rise_irq_en, cmp0_fall_irq_en, cmp0_response_mode})
            `CHK("irq", (i[3] & i[1]) | (i[2] & i[0]), cmp0_irq)
        end
        $display("t_mode done");
    endtask
    // rise then fall must leave both flags set until software clears them
    task automatic t_cmp1;
        wr(CMP1_CTRL_ADDR, 8'hc9);
        rd(CMP1_CTRL_ADDR, 8'h89);
        `CHK("hyst", 4'h9, {cmp1_pos_hyst_code, cmp1_neg_hyst_code})
        `CHK("en", 1'b1, cmp1_enable_bit)
        @(negedge mclk);
        level = 1'b1;
        repeat (4) @(negedge mclk);
        rd(CMP1_CTRL_ADDR, 8'he9);
        `CHK("pin", 1'b1, cmp1_pin_out)
        @(negedge mclk);
        level = 1'b0;
        repeat (4) @(negedge mclk);
        rd(CMP1_CTRL_ADDR, 8'hb9);
        // the rising edge lands in the clearing write's cycle; the set must win
        @(negedge mclk);
        level = 1'b1;
        @(negedge mclk);
        wr(CMP1_CTRL_ADDR, 8'h80);
        rd(CMP1_CTRL_ADDR, 8'he0);
        // disable while the synchronized output is still high: pin drops at once
        wr(CMP1_CTRL_ADDR, 8'h00);
        rd(CMP1_CTRL_ADDR, 8'h40);
        `CHK("pin", 1'b0, cmp1_pin_out)
        repeat (4) @(negedge mclk);
        rd(CMP1_CTRL_ADDR, 8'h10);
        `CHK("pin", 1'b0, cmp1_pin_out)
        `CHK("en", 1'b0, cmp1_enable_bit)
        $display("t_cmp1 done");
    endtask
    // a second reset in mid-run must bring every register back
    task automatic t_rerst;
        wr(CMP0_MUX_ADDR, 8'h44);
        wr(CMP0_MODE_ADDR, 8'h31);
        @(negedge mclk);
        sys_rst = 1'b1;
        repeat (2) @(negedge mclk);
        sys_rst = 1'b0;
        rd(CMP0_MUX_ADDR, CMP0_MUX_RST);
        rd(CMP0_MODE_ADDR, CMP0_MODE_RST);
        rd(CMP1_CTRL_ADDR, CMP1_CTRL_RST);
        $display("t_rerst done");
    endtask
    task automatic results;
        $display("tests %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(negedge mclk);
        sys_rst = 1'b0;
        t_reset();
        t_mux();
        t_mode();
        t_cmp1();
        t_rerst();
        results();
    end
    // the tests need about 200 cycles; 4000 means a hang
    initial
    begin
        #20000;
        err_total++;
        results();
    end
endmodule
